// file: srf_defs.svh
// Constants for the sensor read frame builder.
`ifndef SRF_DEFS_SVH
`define SRF_DEFS_SVH
`define SRF_START_DELIM   8'h7e
`define SRF_FRAME_TYPE    8'h94
`define SRF_LEN_MSB       8'h00
`define SRF_LEN_LSB       8'h17
`define SRF_LAST_IDX      5'd26
`define SRF_OFS_DELIM     5'd0
`define SRF_OFS_LEN_MSB   5'd1
`define SRF_OFS_LEN_LSB   5'd2
`define SRF_OFS_TYPE      5'd3
`define SRF_OFS_A64_LAST  5'd11
`define SRF_OFS_A16_LAST  5'd13
`define SRF_OFS_RXOPT     5'd14
`define SRF_OFS_SENS      5'd15
`define SRF_OFS_AD_FIRST  5'd16
`define SRF_OFS_AD_LAST   5'd23
`define SRF_OFS_TMP_FIRST 5'd24
`define SRF_OFS_TMP_LAST  5'd25
`define SRF_RXOPT_ACK     8'h01
`define SRF_RXOPT_BCAST   8'h02
`define SRF_SENS_AD       8'h01
`define SRF_SENS_TEMP     8'h02
`define SRF_SENS_WATER    8'h60
`define SRF_TEMP_NONE     16'hffff
`define SRF_CKSUM_BASE    8'hff
`define SRF_FIFO_DEPTH    8
`define SRF_FIFO_WIDTH    8
`endif

// file: srf_pkg.sv
// Types for the sensor read frame builder.
package srf_pkg;
  typedef enum logic [1:0] {SRF_IDLE, SRF_SEND, SRF_CKSUM} srf_state_t;
endpackage

// file: srf_fifo.sv
// Byte FIFO between the frame builder and the serial port side.
`timescale 1ns/1ns
module srf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             CLK,
  input  wire logic             RST,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count < (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage has no reset so it can map onto distributed memory.
  always_ff @(posedge CLK) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign out_data = mem[rd_ptr];

  never_over_a: assert property (@(posedge CLK) disable iff (RST)
    count <= (AW+1)'(DEPTH)) else $error("FIFO count above depth.");
endmodule

// file: srf_byte_sel.sv
// Selects the frame byte at a given index from the captured sample.
`timescale 1ns/1ns
module srf_byte_sel (
  input  wire logic [4:0]  idx,
  input  wire logic [63:0] addr64,
  input  wire logic [15:0] addr16,
  input  wire logic [7:0]  rx_opt,
  input  wire logic [7:0]  sensors,
  input  wire logic [63:0] ad_vals,
  input  wire logic [15:0] temp,
  output logic      [7:0]  byte_out
);
  `include "srf_defs.svh"
  always_comb begin
    byte_out = 8'h00;
    if (idx == `SRF_OFS_DELIM) begin
      byte_out = `SRF_START_DELIM;
    end else if (idx == `SRF_OFS_LEN_MSB) begin
      byte_out = `SRF_LEN_MSB;
    end else if (idx == `SRF_OFS_LEN_LSB) begin
      byte_out = `SRF_LEN_LSB;
    end else if (idx == `SRF_OFS_TYPE) begin
      byte_out = `SRF_FRAME_TYPE;
    end else if (idx <= `SRF_OFS_A64_LAST) begin
      byte_out = addr64[8*(`SRF_OFS_A64_LAST-idx) +: 8];
    end else if (idx <= `SRF_OFS_A16_LAST) begin
      byte_out = addr16[8*(`SRF_OFS_A16_LAST-idx) +: 8];
    end else if (idx == `SRF_OFS_RXOPT) begin
      byte_out = rx_opt;
    end else if (idx == `SRF_OFS_SENS) begin
      byte_out = sensors;
    end else if (idx <= `SRF_OFS_AD_LAST) begin
      byte_out = ad_vals[8*(`SRF_OFS_AD_LAST-idx) +: 8];
    end else if (idx <= `SRF_OFS_TMP_LAST) begin
      byte_out = temp[8*(`SRF_OFS_TMP_LAST-idx) +: 8];
    end
  end
endmodule

// file: srf_frame_builder.sv
// Sensor read indication frame builder with output byte FIFO.
`timescale 1ns/1ns
`include "srf_defs.svh"
// Contract
// - On a sample with output format zero, emit a frame of type 0x94.
// - Sender 64-bit address in bytes 4 to 11, most significant first.
// - Sender 16-bit address in bytes 12 and 13, most significant first.
// - Byte 14 holds receive options: 0x01 acknowledged, 0x02 broadcast.
// - Byte 15 sensor content: 0x01 A/D, 0x02 temperature, 0x60 water (pin low).
// - Bytes 16 to 23 carry readings A, B, C, D, two bytes each.
// - Bytes 24 and 25 carry temperature, or 0xffff with no thermometer.
module srf_frame_builder
  import srf_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        SAMPLE_VALID,
  output logic             SAMPLE_READY,
  input  wire logic        OUTPUT_FORMAT_OPTION,
  input  wire logic [63:0] SRC_ADDR64,
  input  wire logic [15:0] SRC_ADDR16,
  input  wire logic        RX_ACKED,
  input  wire logic        RX_BROADCAST,
  input  wire logic        HAS_AD,
  input  wire logic        HAS_TEMP,
  input  wire logic        THERMO_FOUND,
  input  wire logic        WATER_DETECT_PIN,
  input  wire logic [15:0] SENSOR_A_READING,
  input  wire logic [15:0] SENSOR_B_READING,
  input  wire logic [15:0] SENSOR_C_READING,
  input  wire logic [15:0] SENSOR_D_READING,
  input  wire logic [15:0] TEMP_READING,
  output logic [7:0]       TX_DATA,
  output logic             TX_VALID,
  input  wire logic        TX_READY,
  output logic             BUSY
);
  srf_state_t  state;
  srf_state_t  next_state;
  logic [4:0]  idx;
  logic [4:0]  next_idx;
  logic [7:0]  sum;
  logic [7:0]  next_sum;
  logic [63:0] addr64;
  logic [15:0] addr16;
  logic [7:0]  rx_opt;
  logic [7:0]  sensors;
  logic [63:0] ad_vals;
  logic [15:0] temp;
  logic [63:0] next_addr64;
  logic [15:0] next_addr16;
  logic [7:0]  next_rx_opt;
  logic [7:0]  next_sensors;
  logic [63:0] next_ad_vals;
  logic [15:0] next_temp;
  logic [7:0]  sel_byte;
  logic [7:0]  fifo_in;
  logic        fifo_valid;
  logic        fifo_ready;
  logic        take;

  // Samples are refused while a frame is in progress; with format one they are
  // accepted and dropped since this block builds only the format-zero frame.
  assign SAMPLE_READY = (state == SRF_IDLE);
  assign take         = SAMPLE_VALID && SAMPLE_READY && !OUTPUT_FORMAT_OPTION;
  assign BUSY         = (state != SRF_IDLE);

  always_comb begin
    next_addr64  = addr64;
    next_addr16  = addr16;
    next_rx_opt  = rx_opt;
    next_sensors = sensors;
    next_ad_vals = ad_vals;
    next_temp    = temp;
    if (take) begin
      next_addr64  = SRC_ADDR64;
      next_addr16  = SRC_ADDR16;
      next_rx_opt  = (RX_ACKED ? `SRF_RXOPT_ACK : 8'h00)
                   | (RX_BROADCAST ? `SRF_RXOPT_BCAST : 8'h00);
      next_sensors = (HAS_AD ? `SRF_SENS_AD : 8'h00)
                   | (HAS_TEMP ? `SRF_SENS_TEMP : 8'h00)
                   | (!WATER_DETECT_PIN ? `SRF_SENS_WATER : 8'h00);
      next_ad_vals = {SENSOR_A_READING, SENSOR_B_READING,
                      SENSOR_C_READING, SENSOR_D_READING};
      next_temp    = THERMO_FOUND ? TEMP_READING : `SRF_TEMP_NONE;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      addr64  <= 64'h0;
      addr16  <= 16'h0;
      rx_opt  <= 8'h00;
      sensors <= 8'h00;
      ad_vals <= 64'h0;
      temp    <= 16'h0;
    end else begin
      addr64  <= next_addr64;
      addr16  <= next_addr16;
      rx_opt  <= next_rx_opt;
      sensors <= next_sensors;
      ad_vals <= next_ad_vals;
      temp    <= next_temp;
    end
  end

  srf_byte_sel u_sel (
    .idx      (idx),
    .addr64   (addr64),
    .addr16   (addr16),
    .rx_opt   (rx_opt),
    .sensors  (sensors),
    .ad_vals  (ad_vals),
    .temp     (temp),
    .byte_out (sel_byte)
  );

  assign fifo_in    = (state == SRF_CKSUM) ? (`SRF_CKSUM_BASE - sum) : sel_byte;
  assign fifo_valid = (state != SRF_IDLE);

  always_comb begin
    next_state = state;
    next_idx   = idx;
    next_sum   = sum;
    case (state)
      SRF_IDLE: begin
        if (take) begin
          next_state = SRF_SEND;
          next_idx   = 5'd0;
          next_sum   = 8'h00;
        end
      end
      SRF_SEND: begin
        if (fifo_ready) begin
          // The checksum covers frame data only, from the type byte onward.
          if (idx >= `SRF_OFS_TYPE) begin
            next_sum = sum + sel_byte;
          end
          if (idx == `SRF_OFS_TMP_LAST) begin
            next_state = SRF_CKSUM;
          end
          next_idx = idx + 5'd1;
        end
      end
      SRF_CKSUM: begin
        if (fifo_ready) begin
          next_state = SRF_IDLE;
          next_idx   = 5'd0;
        end
      end
      default: next_state = SRF_IDLE;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= SRF_IDLE;
      idx   <= 5'd0;
      sum   <= 8'h00;
    end else begin
      state <= next_state;
      idx   <= next_idx;
      sum   <= next_sum;
    end
  end

  srf_fifo #(
    .WIDTH (`SRF_FIFO_WIDTH),
    .DEPTH (`SRF_FIFO_DEPTH)
  ) u_fifo (
    .CLK       (CLK),
    .RST       (RST),
    .in_data   (fifo_in),
    .in_valid  (fifo_valid),
    .in_ready  (fifo_ready),
    .out_data  (TX_DATA),
    .out_valid (TX_VALID),
    .out_ready (TX_READY)
  );

  // Bytes handed to the FIFO in this frame, counted apart from idx so that the
  // length check does not lean on the counter that it watches.
  logic [4:0]  sent;
  logic [4:0]  next_sent;

  always_comb begin
    next_sent = sent;
    if (take) begin
      next_sent = 5'd0;
    end else if (fifo_valid && fifo_ready) begin
      next_sent = sent + 5'd1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sent <= 5'd0;
    end else begin
      sent <= next_sent;
    end
  end

  type_byte_a: assert property (@(posedge CLK) disable iff (RST)
    (state == SRF_SEND && idx == 5'd3) |-> sel_byte == `SRF_FRAME_TYPE)
    else $error("Frame type byte wrong.");
  format_gate_a: assert property (@(posedge CLK) disable iff (RST)
    (state == SRF_IDLE && SAMPLE_VALID && OUTPUT_FORMAT_OPTION) |=> state == SRF_IDLE)
    else $error("Frame started with format one.");
  addr_msb_a: assert property (@(posedge CLK) disable iff (RST)
    (state == SRF_SEND && idx == 5'd4) |-> sel_byte == addr64[63:56])
    else $error("Address high byte wrong.");
  short_msb_a: assert property (@(posedge CLK) disable iff (RST)
    (state == SRF_SEND && idx == 5'd12) |-> sel_byte == addr16[15:8])
    else $error("Short address high byte wrong.");
  rx_opt_a: assert property (@(posedge CLK) disable iff (RST)
    take |=> rx_opt[1:0] == {$past(RX_BROADCAST), $past(RX_ACKED)})
    else $error("Receive options wrong.");
  water_bit_a: assert property (@(posedge CLK) disable iff (RST)
    take |=> sensors[6:5] == {2{!$past(WATER_DETECT_PIN)}} && sensors[1] == $past(HAS_TEMP))
    else $error("Sensor content wrong.");
  sensor_d_a: assert property (@(posedge CLK) disable iff (RST)
    (state == SRF_SEND && idx == 5'd23) |-> sel_byte == ad_vals[7:0])
    else $error("Sensor D low byte wrong.");
  no_thermo_a: assert property (@(posedge CLK) disable iff (RST)
    (take && !THERMO_FOUND) |=> temp == `SRF_TEMP_NONE)
    else $error("Missing thermometer not flagged.");
  delim_first_a: assert property (@(posedge CLK) disable iff (RST)
    (state == SRF_IDLE && take) |=> (state == SRF_SEND && idx == 5'd0
      && sel_byte == `SRF_START_DELIM && sum == 8'h00))
    else $error("Frame did not start with delimiter.");
  len_msb_a: assert property (@(posedge CLK) disable iff (RST)
    (state == SRF_SEND && idx == `SRF_OFS_LEN_MSB) |-> sel_byte == `SRF_LEN_MSB)
    else $error("Length high byte wrong.");
  len_lsb_a: assert property (@(posedge CLK) disable iff (RST)
    (state == SRF_SEND && idx == `SRF_OFS_LEN_LSB) |-> sel_byte == `SRF_LEN_LSB)
    else $error("Length low byte wrong.");
  addr_lsb_a: assert property (@(posedge CLK) disable iff (RST)
    (state == SRF_SEND && idx == `SRF_OFS_A64_LAST) |-> sel_byte == addr64[7:0])
    else $error("Address low byte wrong.");
  short_lsb_a: assert property (@(posedge CLK) disable iff (RST)
    (state == SRF_SEND && idx == `SRF_OFS_A16_LAST) |-> sel_byte == addr16[7:0])
    else $error("Short address low byte wrong.");
  opt_byte_a: assert property (@(posedge CLK) disable iff (RST)
    (state == SRF_SEND && idx == `SRF_OFS_RXOPT) |-> sel_byte == rx_opt)
    else $error("Receive option byte misplaced.");
  sens_byte_a: assert property (@(posedge CLK) disable iff (RST)
    (state == SRF_SEND && idx == `SRF_OFS_SENS) |-> sel_byte == sensors)
    else $error("Sensor content byte misplaced.");
  sensor_a_a: assert property (@(posedge CLK) disable iff (RST)
    (state == SRF_SEND && idx == `SRF_OFS_AD_FIRST) |-> sel_byte == ad_vals[63:56])
    else $error("Sensor A high byte wrong.");
  sensor_b_a: assert property (@(posedge CLK) disable iff (RST)
    (state == SRF_SEND && idx == `SRF_OFS_AD_FIRST + 5'd2) |-> sel_byte == ad_vals[47:40])
    else $error("Sensor B high byte wrong.");
  temp_high_a: assert property (@(posedge CLK) disable iff (RST)
    (state == SRF_SEND && idx == `SRF_OFS_TMP_FIRST) |-> sel_byte == temp[15:8])
    else $error("Temperature high byte wrong.");
  temp_low_a: assert property (@(posedge CLK) disable iff (RST)
    (state == SRF_SEND && idx == `SRF_OFS_TMP_LAST) |-> sel_byte == temp[7:0])
    else $error("Temperature low byte wrong.");
  thermo_kept_a: assert property (@(posedge CLK) disable iff (RST)
    (take && THERMO_FOUND) |=> temp == $past(TEMP_READING))
    else $error("Temperature reading not kept.");
  ad_capture_a: assert property (@(posedge CLK) disable iff (RST)
    take |=> ad_vals == {$past(SENSOR_A_READING), $past(SENSOR_B_READING),
                         $past(SENSOR_C_READING), $past(SENSOR_D_READING)})
    else $error("Sensor readings not captured in order.");
  addr_capture_a: assert property (@(posedge CLK) disable iff (RST)
    take |=> addr64 == $past(SRC_ADDR64) && addr16 == $past(SRC_ADDR16))
    else $error("Sender addresses not captured.");
  rx_clear_a: assert property (@(posedge CLK) disable iff (RST)
    take |=> rx_opt[7:2] == 6'h00)
    else $error("Unused receive option bits set.");
  sens_fields_a: assert property (@(posedge CLK) disable iff (RST)
    take |=> sensors[1:0] == {$past(HAS_TEMP), $past(HAS_AD)}
      && sensors[7] == 1'b0 && sensors[4:2] == 3'h0)
    else $error("Sensor content bits do not combine.");
  hold_fields_a: assert property (@(posedge CLK) disable iff (RST)
    (state != SRF_IDLE) |=> $stable(addr64) && $stable(ad_vals) && $stable(temp))
    else $error("Captured fields changed during a frame.");
  stall_hold_a: assert property (@(posedge CLK) disable iff (RST)
    (state == SRF_SEND && !fifo_ready) |=> $stable(idx) && $stable(sum))
    else $error("Frame advanced while the FIFO was full.");
  frame_len_a: assert property (@(posedge CLK) disable iff (RST)
    (state == SRF_CKSUM && fifo_ready) |-> sent == `SRF_LAST_IDX)
    else $error("Checksum not at the last offset.");
  ready_again_a: assert property (@(posedge CLK) disable iff (RST)
    (state == SRF_CKSUM && fifo_ready) |=> SAMPLE_READY)
    else $error("Not ready after the checksum.");
  frame_cover_c: cover property (@(posedge CLK) disable iff (RST)
    state == SRF_CKSUM && fifo_ready);
  stall_cover_c: cover property (@(posedge CLK) disable iff (RST)
    state == SRF_SEND && !fifo_ready);
  both_cover_c: cover property (@(posedge CLK) disable iff (RST)
    take && HAS_AD && HAS_TEMP);
  water_cover_c: cover property (@(posedge CLK) disable iff (RST)
    take && !WATER_DETECT_PIN);
  drop_cover_c: cover property (@(posedge CLK) disable iff (RST)
    state == SRF_IDLE && SAMPLE_VALID && OUTPUT_FORMAT_OPTION);
endmodule

// file: srf_host.sv
// Host model that reads the serial port byte stream of the frame builder.
`timescale 1ns/1ns
module srf_host (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       slow,
  output logic            tx_ready
);
  logic [7:0] got [$];
  logic [1:0] phase;

  // A slow host takes one byte in four cycles, so the FIFO fills and the builder must wait.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      phase    <= 2'h0;
      tx_ready <= 1'b0;
    end else begin
      phase    <= phase + 2'h1;
      tx_ready <= !slow || (phase == 2'h3);
      if (tx_valid && tx_ready) begin
        got.push_back(tx_data);
      end
    end
  end

  // Temperature in sixteenths of a degree, negative from 2048 upwards.
  function automatic logic [15:0] decode_temp(input logic [15:0] raw);
    return (raw < 16'd2048) ? raw : -(raw & 16'h07ff);
  endfunction
endmodule

// file: srf_frame_builder_bench.sv
// Self-checking bench for the sensor read frame builder.
`timescale 1ns/1ns
module srf_frame_builder_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sv = 1'b0, fmt = 1'b0, slow = 1'b0;
  logic        ack = 1'b0, bc = 1'b0, had = 1'b0, hte = 1'b0, thf = 1'b0, wdp = 1'b1;
  logic [63:0] a64 = 64'h0;
  logic [15:0] a16 = 16'h0, ra = 16'h0, rb = 16'h0, rc = 16'h0, rd = 16'h0, tr = 16'h0;
  logic        ready, tx_valid, tx_ready, busy;
  logic [7:0]  tx_data;
  logic [7:0]  exp_q [$];
  int          mismatches = 0;
  int          checks = 0;
  int          i;

  srf_frame_builder u_srf_frame_builder (.CLK(clk), .RST(rst), .SAMPLE_VALID(sv),
    .SAMPLE_READY(ready), .OUTPUT_FORMAT_OPTION(fmt), .SRC_ADDR64(a64), .SRC_ADDR16(a16),
    .RX_ACKED(ack), .RX_BROADCAST(bc), .HAS_AD(had), .HAS_TEMP(hte), .THERMO_FOUND(thf),
    .WATER_DETECT_PIN(wdp), .SENSOR_A_READING(ra), .SENSOR_B_READING(rb),
    .SENSOR_C_READING(rc), .SENSOR_D_READING(rd), .TEMP_READING(tr), .TX_DATA(tx_data),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .BUSY(busy));
  srf_host u_srf_host (.clk(clk), .rst(rst), .tx_data(tx_data), .tx_valid(tx_valid),
    .slow(slow), .tx_ready(tx_ready));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out;
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Offers one sample, holding it until taken, and queues the frame it must produce.
  task automatic offer(input logic f, input logic [63:0] a, input logic [15:0] n,
                       input logic [5:0] flg, input logic [63:0] ad, input logic [15:0] t);
    logic [7:0] fr [$];
    logic [7:0] sum;
    int         k;
    int         w;
    @(posedge clk);
    fmt <= f;
    a64 <= a;
    a16 <= n;
    {ack, bc, had, hte, thf, wdp} <= flg;
    {ra, rb, rc, rd} <= ad;
    tr <= t;
    sv <= 1'b1;
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (ready !== 1'b1 && w < 200);
    sv <= 1'b0;
    if (w >= 200) begin
      mismatches++;
      close_out();
    end
    if (f == 1'b0) begin
      fr = {8'h7e, 8'h00, 8'h17, 8'h94};
      for (k = 7; k >= 0; k--) fr.push_back(a[k*8 +: 8]);
      fr.push_back(n[15:8]);
      fr.push_back(n[7:0]);
      fr.push_back({6'h0, flg[4], flg[5]});
      fr.push_back({1'b0, {2{~flg[0]}}, 3'h0, flg[2], flg[3]});
      for (k = 7; k >= 0; k--) fr.push_back(ad[k*8 +: 8]);
      fr.push_back(flg[1] ? t[15:8] : 8'hff);
      fr.push_back(flg[1] ? t[7:0] : 8'hff);
      sum = 8'h00;
      for (k = 3; k < 26; k++) sum = sum + fr[k];
      fr.push_back(8'hff - sum);
      foreach (fr[k]) exp_q.push_back(fr[k]);
      #1;
      check("ready after take", {15'h0, ready}, 16'h0);
      @(posedge clk);
      #1;
      check("busy", {15'h0, busy}, 16'h1);
    end
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    offer(1'b0, 64'h0123456789abcdef, 16'hdd6c, 6'b101111,
          {16'h0002, 16'h00ce, 16'h00ea, 16'h0052}, 16'h016a);
    // A sample in the other output format is taken but must leave no bytes behind.
    offer(1'b1, 64'h1111111111111111, 16'h2222, 6'b111111, 64'h0, 16'h0);
    slow <= 1'b1;
    offer(1'b0, 64'hfedcba9876543210, 16'h0001, 6'b010100,
          {16'hffff, 16'h8000, 16'h0001, 16'h7ffe}, 16'h1234);
    offer(1'b0, 64'h8000000000000001, 16'hfffe, 6'b110011,
          {16'h0102, 16'h0304, 16'h0506, 16'h0708}, 16'h0805);
    for (i = 0; i < 4000 && u_srf_host.got.size() < exp_q.size(); i++) @(posedge clk);
    if (i >= 4000) mismatches++;
    repeat (40) @(posedge clk);
    #1;
    check("byte count", 16'(u_srf_host.got.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) begin
      if (i < u_srf_host.got.size()) begin
        // Every field sits at its fixed offset, checksum last.
        check("frame byte", {8'h0, u_srf_host.got[i]}, {8'h0, exp_q[i]});
      end
    end
    check("temp plus", u_srf_host.decode_temp(16'h016a), 16'd362);
    check("temp minus", u_srf_host.decode_temp(16'h0805), 16'hfffb);
    check("busy at end", {15'h0, busy}, 16'h0);
    check("ready at end", {15'h0, ready}, 16'h1);
    check("drained", {15'h0, tx_valid}, 16'h0);
    close_out();
  end
endmodule
